// *** shared/fpg_pkg.sv ***
// Purpose: Constants and types shared by the flash guard controller files
// Assumes: 25 MHz system clock, 32-bit APB register port
// Notes: Times are kept in their own unit; cycle counts derive from them
package fpg_pkg;

	localparam int CLK_PERIOD_NS = 40;
	// Least waits, rounded up to whole clock cycles
	localparam int SWE_WAIT_NS = 100000;
	localparam int RST_HOLD_NS = 100000;
	localparam int SWE_WAIT_CYC = (SWE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 12;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] BLOCK_OFS = 8'h08;

	// Control register fields
	localparam int CTRL_W = 14;
	localparam int C_FWE = 0;
	localparam int C_SWE = 1;
	localparam int C_OPS_LO = 2;
	localparam int C_OPS_HI = 7;
	localparam int C_WDT = 8;
	localparam int C_KEEP = 9;
	localparam int C_STS_LO = 10;
	localparam int C_STS_HI = 12;
	localparam int C_RST = 13;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 14'h0000;

	// Operation bit order inside the six-bit group
	localparam int OP_ESU = 0;
	localparam int OP_PSU = 1;
	localparam int OP_EV = 2;
	localparam int OP_PV = 3;
	localparam int OP_PGM = 4;
	localparam int OP_ERS = 5;

	// Status register fields
	localparam int S_FWE = 0;
	localparam int S_SWE = 1;
	localparam int S_READ_OK = 2;
	localparam int S_CHIP_RST = 3;
	localparam int S_BUSY = 4;
	localparam int S_REFUSED = 5;
	localparam int S_BLK_PGM = 6;

	// Least standby wait select code that gives the supply settling time
	localparam logic [2:0] STS_MIN_DEFAULT = 3'h5;

	typedef enum logic [1:0] {
		FPG_POR,
		FPG_RUN,
		FPG_RST_WAIT,
		FPG_RST_HOLD
	} fpg_state_t;

endpackage

// *** rtl/fpg_block_map.sv ***
// Purpose: One bit per programming unit block, set when programmed
// Assumes: All blocks start erased after reset
// Notes: Read data is registered, one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module fpg_block_map #(
	parameter int DEPTH = 1024,
	parameter int AW = 10
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Access
	input wire logic [AW-1:0] addr,
	input wire logic we,
	input wire logic wdata,
	output logic rdata
);

	typedef struct packed {
		logic [DEPTH-1:0] bits;
		logic rdata;
	} fpg_map_t;

	fpg_map_t s_q;
	fpg_map_t s_d;

	always_comb
	begin
		s_d = s_q;
		if (we)
			s_d.bits[addr] = wdata;
		s_d.rdata = s_q.bits[addr];
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign rdata = s_q.rdata;

endmodule // fpg_block_map
`default_nettype wire

// *** rtl/fpg_host.sv ***
// Purpose: Controller that drives the flash write-enable pin and mode bits
// Assumes: Software orders it over APB; pin levels are synchronous
// Notes: Orders that would break the flash ordering are held off or refused
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module fpg_host #(
	parameter int ADDR_W = 8,
	parameter int BLOCKS = 1024,
	parameter int BLK_W = 10,
	parameter logic [2:0] STS_MIN = fpg_pkg::STS_MIN_DEFAULT
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Chip straps
	input wire logic boot_mode,
	// Flash control pins and bits
	output logic write_enable_pin,
	output logic software_write_enable_bit,
	output logic erase_setup_bit,
	output logic program_setup_bit,
	output logic erase_verify_bit,
	output logic program_verify_bit,
	output logic program_pulse_bit,
	output logic erase_pulse_bit,
	output logic subclock_power_keep_bit,
	output logic [2:0] standby_wait_select,
	// System side
	output logic chip_reset,
	output logic irq_disable,
	output logic watchdog_run,
	output logic flash_read_ok
);

	typedef struct packed {
		fpg_pkg::fpg_state_t st;
		logic [fpg_pkg::CNT_W-1:0] hold_cnt;
		logic [fpg_pkg::CNT_W-1:0] swe_cnt;
		logic [fpg_pkg::CTRL_W-1:0] ctrl;
		logic [BLK_W-1:0] blk;
		logic refused;
		logic flash_write_enable_pin;
		logic swe;
		logic [5:0] ops;
		logic wdt;
		logic keep;
		logic [2:0] sts;
		logic chip_rst;
		logic read_ok;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} fpg_host_t;

	localparam logic [fpg_pkg::CNT_W-1:0] SWE_DONE = fpg_pkg::CNT_W'(fpg_pkg::SWE_WAIT_CYC);
	localparam logic [fpg_pkg::CNT_W-1:0] HOLD_DONE = fpg_pkg::CNT_W'(fpg_pkg::RST_HOLD_CYC);

	fpg_host_t s_q;
	fpg_host_t s_d;
	logic map_we;
	logic map_wdata;
	logic blk_programmed;

	fpg_block_map #(
		.DEPTH(BLOCKS),
		.AW(BLK_W)
	) u_map (
		.clock(clock),
		.rst(rst),
		.addr(s_q.blk),
		.we(map_we),
		.wdata(map_wdata),
		.rdata(blk_programmed)
	);

	always_comb
	begin
		logic setup;
		logic wr;
		logic mapped;
		logic ref_set;
		logic swe_settled;
		logic [5:0] ops_req;
		logic [5:0] ops_new;
		logic [2:0] sts_req;
		logic [6:0] status_bits;
		setup = psel & ~penable;
		wr = psel & penable & s_q.pready & pwrite;
		mapped = (paddr[7:0] == fpg_pkg::CTRL_OFS) || (paddr[7:0] == fpg_pkg::STATUS_OFS)
			|| (paddr[7:0] == fpg_pkg::BLOCK_OFS);
		ref_set = 1'b0;
		swe_settled = ~s_q.swe && (s_q.swe_cnt == SWE_DONE);
		ops_req = s_q.ctrl[fpg_pkg::C_OPS_HI:fpg_pkg::C_OPS_LO];
		sts_req = s_q.ctrl[fpg_pkg::C_STS_HI:fpg_pkg::C_STS_LO];
		ops_new = s_q.ops;
		status_bits = 7'h00;
		status_bits[fpg_pkg::S_FWE] = s_q.flash_write_enable_pin;
		status_bits[fpg_pkg::S_SWE] = s_q.swe;
		status_bits[fpg_pkg::S_READ_OK] = s_q.read_ok;
		status_bits[fpg_pkg::S_CHIP_RST] = s_q.chip_rst;
		status_bits[fpg_pkg::S_BUSY] = s_q.st != fpg_pkg::FPG_RUN;
		status_bits[fpg_pkg::S_REFUSED] = s_q.refused;
		status_bits[fpg_pkg::S_BLK_PGM] = blk_programmed;
		map_we = 1'b0;
		map_wdata = 1'b0;
		s_d = s_q;

		// Zero-wait slave: read data and error are loaded in the setup cycle
		s_d.pready = setup & ~s_q.pready;
		if (setup)
		begin
			// Unmapped addresses answer with an error and read as zero
			s_d.pslverr = ~mapped;
			unique case (paddr[7:0])
				fpg_pkg::CTRL_OFS: s_d.prdata = 32'(s_q.ctrl);
				fpg_pkg::STATUS_OFS: s_d.prdata = 32'(status_bits);
				fpg_pkg::BLOCK_OFS: s_d.prdata = 32'(s_q.blk);
				default: s_d.prdata = 32'h0000_0000;
			endcase
		end
		if (wr && paddr[7:0] == fpg_pkg::CTRL_OFS)
			s_d.ctrl = pwdata[fpg_pkg::CTRL_W-1:0];
		if (wr && paddr[7:0] == fpg_pkg::BLOCK_OFS)
			s_d.blk = pwdata[BLK_W-1:0];
		// Status is read-only apart from clearing the sticky refusal
		if (wr && paddr[7:0] == fpg_pkg::STATUS_OFS && pwdata[fpg_pkg::S_REFUSED])
			s_d.refused = 1'b0;

		// The supply settling wait is never shorter than the minimum code
		s_d.sts = (sts_req < STS_MIN) ? STS_MIN : sts_req;
		s_d.keep = s_q.ctrl[fpg_pkg::C_KEEP];
		s_d.wdt = s_q.ctrl[fpg_pkg::C_WDT];

		// Time since the write-enable bit was last cleared
		// Saturates at the wait, so idle spans of any length need no wider counter
		if (s_q.swe)
			s_d.swe_cnt = '0;
		else if (s_q.swe_cnt != SWE_DONE)
			s_d.swe_cnt = s_q.swe_cnt + 1'b1;

		unique case (s_q.st)
			fpg_pkg::FPG_POR:
			begin
				// Chip reset covers the settling time after power-on
				s_d.chip_rst = 1'b1;
				s_d.hold_cnt = s_q.hold_cnt + 1'b1;
				if (s_q.hold_cnt == HOLD_DONE)
				begin
					s_d.chip_rst = 1'b0;
					s_d.st = fpg_pkg::FPG_RUN;
				end
			end
			fpg_pkg::FPG_RUN:
			begin
				// Operation bits follow software only under a live write enable
				ops_new = ops_req & {6{s_q.swe & s_q.ctrl[fpg_pkg::C_SWE]}};
				// Pulses need a watchdog already running one cycle before
				if ((ops_new[fpg_pkg::OP_PGM] | ops_new[fpg_pkg::OP_ERS]) & ~s_q.wdt)
				begin
					ops_new[fpg_pkg::OP_PGM] = s_q.ops[fpg_pkg::OP_PGM] & s_q.wdt;
					ops_new[fpg_pkg::OP_ERS] = s_q.ops[fpg_pkg::OP_ERS] & s_q.wdt;
					ref_set = 1'b1;
				end
				// A block already programmed must be erased before programming again
				if (ops_new[fpg_pkg::OP_PGM] & ~s_q.ops[fpg_pkg::OP_PGM] & blk_programmed)
				begin
					ops_new[fpg_pkg::OP_PGM] = 1'b0;
					ref_set = 1'b1;
				end
				if (ops_new[fpg_pkg::OP_PGM] & ~s_q.ops[fpg_pkg::OP_PGM])
				begin
					map_we = 1'b1;
					map_wdata = 1'b1;
				end
				// Erase clears only the block that the block register selects
				if (ops_new[fpg_pkg::OP_ERS] & ~s_q.ops[fpg_pkg::OP_ERS])
					map_we = 1'b1;
				s_d.ops = ops_new;
				// Write enable drops only a cycle after every operation bit has gone
				s_d.swe = s_q.flash_write_enable_pin & (s_q.ctrl[fpg_pkg::C_SWE] | (s_q.ops != 6'h00));
				if (s_q.ctrl[fpg_pkg::C_SWE] & ~s_q.flash_write_enable_pin)
					ref_set = 1'b1;
				// Pin moves only with all bits clear, in either direction; a drop also
				// waits out a write-enable request, which would rise in the same cycle
				if (s_q.ctrl[fpg_pkg::C_FWE] != s_q.flash_write_enable_pin && ~s_q.swe && s_q.ops == 6'h00
					&& ~(s_q.flash_write_enable_pin & s_q.ctrl[fpg_pkg::C_SWE]))
				begin
					if (boot_mode)
						s_d.st = fpg_pkg::FPG_RST_WAIT;
					else
						s_d.flash_write_enable_pin = s_q.ctrl[fpg_pkg::C_FWE];
				end
				if (s_q.ctrl[fpg_pkg::C_RST])
				begin
					s_d.ctrl[fpg_pkg::C_RST] = 1'b0;
					s_d.st = fpg_pkg::FPG_RST_WAIT;
				end
			end
			fpg_pkg::FPG_RST_WAIT:
			begin
				// Bits are dropped first, then the settling wait runs out
				s_d.ops = 6'h00;
				s_d.swe = s_q.flash_write_enable_pin & (s_q.ops != 6'h00);
				if (swe_settled)
				begin
					s_d.chip_rst = 1'b1;
					s_d.hold_cnt = '0;
					s_d.st = fpg_pkg::FPG_RST_HOLD;
				end
			end
			fpg_pkg::FPG_RST_HOLD:
			begin
				s_d.hold_cnt = s_q.hold_cnt + 1'b1;
				// In boot mode the pin only moves while the chip is held in reset
				if (boot_mode)
					s_d.flash_write_enable_pin = s_q.ctrl[fpg_pkg::C_FWE];
				if (s_q.hold_cnt == HOLD_DONE)
				begin
					s_d.chip_rst = 1'b0;
					s_d.st = fpg_pkg::FPG_RUN;
				end
			end
		endcase

		// Array reads: only verify while enabled, else after the settling wait
		if (s_d.swe)
			s_d.read_ok = s_d.ops[fpg_pkg::OP_EV] | s_d.ops[fpg_pkg::OP_PV];
		else
			s_d.read_ok = ~s_q.swe && (s_q.swe_cnt == SWE_DONE) && ~s_d.chip_rst;

		// A new refusal wins over a software clear in the same cycle
		if (ref_set)
			s_d.refused = 1'b1;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			s_q <= '0;
			s_q.st <= fpg_pkg::FPG_POR;
			s_q.chip_rst <= 1'b1;
			// Counts as settled, so the power-on hold alone gates the first reads
			s_q.swe_cnt <= SWE_DONE;
			s_q.ctrl <= fpg_pkg::CTRL_RESET;
			s_q.sts <= STS_MIN;
		end
		else
			s_q <= s_d;
	end

	// Every output is a register field; nothing combinational leaves the block
	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign write_enable_pin = s_q.flash_write_enable_pin;
	assign software_write_enable_bit = s_q.swe;
	assign erase_setup_bit = s_q.ops[fpg_pkg::OP_ESU];
	assign program_setup_bit = s_q.ops[fpg_pkg::OP_PSU];
	assign erase_verify_bit = s_q.ops[fpg_pkg::OP_EV];
	assign program_verify_bit = s_q.ops[fpg_pkg::OP_PV];
	assign program_pulse_bit = s_q.ops[fpg_pkg::OP_PGM];
	assign erase_pulse_bit = s_q.ops[fpg_pkg::OP_ERS];
	assign subclock_power_keep_bit = s_q.keep;
	assign standby_wait_select = s_q.sts;
	assign chip_reset = s_q.chip_rst;
	// Interrupts stay masked for the whole time the pin is applied
	assign irq_disable = s_q.flash_write_enable_pin;
	assign watchdog_run = s_q.wdt;
	assign flash_read_ok = s_q.read_ok;

endmodule // fpg_host
`default_nettype wire

// *** verification/fpg_flash_model.sv ***
// Purpose: Flash array gate model
// Assumes: chip_mode 0 run, 1 subclock, 2 standby
// Notes: Flags a program pulse into a closed array
`timescale 1ns/1ps
`default_nettype none
module fpg_flash_model (
	// Clock and mode
	input wire logic clock,
	input wire logic rst,
	input wire logic [1:0] chip_mode,
	// Controller pins
	input wire logic write_enable_pin,
	input wire logic software_write_enable_bit,
	input wire logic program_pulse_bit,
	input wire logic subclock_power_keep_bit,
	input wire logic flash_read_ok,
	// Array state
	output logic power_down,
	output logic read_open,
	output logic misuse
);
	logic write_open;
	// Keep bit only counts on the subclock
	assign power_down = chip_mode == 2'h1 && !subclock_power_keep_bit;
	assign read_open = chip_mode != 2'h2 && flash_read_ok;
	assign write_open = chip_mode == 2'h0 && write_enable_pin && software_write_enable_bit;
	// Pin level alone never upsets the array
	always_ff @(posedge clock)
		misuse <= !rst && (misuse || program_pulse_bit && !write_open);
endmodule // fpg_flash_model
`default_nettype wire

// *** verification/fpg_host_properties.sv ***
// Purpose: Pin timing checks for the flash guard
// Assumes: One clock, synchronous reset
// Notes: Idle count saturates so long spans stay legal
`timescale 1ns/1ps
`default_nettype none
module fpg_host_properties (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Watched pins
	input wire logic boot_mode,
	input wire logic write_enable_pin,
	input wire logic software_write_enable_bit,
	input wire logic erase_setup_bit,
	input wire logic program_setup_bit,
	input wire logic erase_verify_bit,
	input wire logic program_verify_bit,
	input wire logic program_pulse_bit,
	input wire logic erase_pulse_bit,
	input wire logic chip_reset,
	input wire logic irq_disable,
	input wire logic watchdog_run,
	input wire logic flash_read_ok
);
	logic quiet, clean, vfy;
	logic [11:0] idle_q;
	assign quiet = {erase_setup_bit, program_setup_bit, erase_verify_bit, program_verify_bit,
		program_pulse_bit, erase_pulse_bit} == 6'h00;
	assign clean = quiet && !software_write_enable_bit;
	assign vfy = erase_verify_bit || program_verify_bit;
	// Cycles since write enable was last high
	always_ff @(posedge clock)
		if (rst || software_write_enable_bit)
			idle_q <= 12'h000;
		else if (idle_q != 12'hFFF)
			idle_q <= idle_q + 12'h001;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_pulse;
		$rose(program_pulse_bit || erase_pulse_bit);
	endsequence
	a_pin_drop_clean:
		assert property ($fell(write_enable_pin) |-> clean) else $error("pin drop");
	a_boot_pin_reset:
		assert property (boot_mode && $changed(write_enable_pin) |-> chip_reset) else $error("boot");
	a_swe_after_ops:
		assert property ($fell(software_write_enable_bit) |-> $past(quiet)) else $error("swe drop");
	a_pulse_needs_wdt:
		assert property (s_pulse |-> $past(watchdog_run)) else $error("pulse");
	a_irq_with_pin:
		assert property (irq_disable == write_enable_pin) else $error("irq");
	a_verify_reads:
		assert property (software_write_enable_bit && $past(software_write_enable_bit)
			&& flash_read_ok |-> vfy || $past(vfy)) else $error("read");
	a_read_wait:
		assert property (!software_write_enable_bit && !$past(software_write_enable_bit)
			&& flash_read_ok |-> idle_q >= 12'h9C4) else $error("early read");
	a_reset_wait:
		assert property ($changed(chip_reset) |-> idle_q >= 12'h9C4) else $error("reset");
endmodule // fpg_host_properties
bind fpg_host fpg_host_properties u_props (.*);
`default_nettype wire

// *** verification/fpg_host_tb_top.sv ***
// Purpose: APB bench for the flash guard
// Assumes: Waits poll STATUS, never fixed counts
// Notes: Real 100 us waits (2500 cycles each, two of them) make the run about 5k cycles
`timescale 1ns/1ps
`default_nettype none
module fpg_host_tb_top;
	localparam logic [31:0] PIN = 32'h1, SWE = 32'h2, EV = 32'h10, PGM = 32'h40, WDT = 32'h100;
	localparam logic [7:0] CT = fpg_pkg::CTRL_OFS;
	localparam logic [7:0] ST = fpg_pkg::STATUS_OFS;
	logic clock, rst, psel, penable, pwrite, pready, pslverr, boot_mode;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [2:0] standby_wait_select;
	logic [1:0] chip_mode;
	logic write_enable_pin, software_write_enable_bit, erase_setup_bit, program_setup_bit;
	logic erase_verify_bit, program_verify_bit, program_pulse_bit, erase_pulse_bit;
	logic subclock_power_keep_bit, chip_reset, irq_disable, watchdog_run, flash_read_ok;
	logic power_down, read_open, misuse;
	int n_mismatch = 0;
	int checks_done = 0;
	fpg_host DUT (.*);
	fpg_flash_model u_flash (.*);
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		rdat = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("FAIL %0t %h %h", $time, g, e);
		end
	endtask
	task bit_is(input int b, input logic v);
		apb(1'b0, ST, 32'h0);
		for (int i = 0; i < 3000 && rdat[b] !== v; i++)
			apb(1'b0, ST, 32'h0);
		chk(rdat[b], v);
	endtask
	task tally_and_finish;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		#1600000;
		n_mismatch++;
		tally_and_finish;
	end
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, boot_mode, chip_mode} = '0;
		rst = 1'b1;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		bit_is(3, 1'b1);
		bit_is(3, 1'b0);
		bit_is(2, 1'b1);
		chk(read_open, 1'b1);
		chk(standby_wait_select, fpg_pkg::STS_MIN_DEFAULT);
		apb(1'b1, CT, PIN);
		bit_is(0, 1'b1);
		chk(irq_disable, 1'b1);
		apb(1'b1, CT, PIN | SWE | PGM);
		bit_is(5, 1'b1);
		apb(1'b1, CT, PIN | SWE | WDT);
		apb(1'b1, ST, 32'h20);
		bit_is(5, 1'b0);
		chk(watchdog_run, 1'b1);
		apb(1'b1, CT, PIN | SWE | WDT | PGM);
		bit_is(6, 1'b1);
		apb(1'b1, CT, PIN | SWE | WDT);
		apb(1'b1, CT, PIN | SWE | WDT | PGM);
		bit_is(5, 1'b1);
		chk(program_pulse_bit, 1'b0);
		chk(misuse, 1'b0);
		apb(1'b1, CT, PIN | SWE | EV);
		bit_is(2, 1'b1);
		chk(erase_verify_bit, 1'b1);
		chip_mode <= 2'h1;
		apb(1'b1, CT, 32'h1C00);
		bit_is(0, 1'b0);
		chk(flash_read_ok, 1'b0);
		chk(power_down, 1'b1);
		chk(standby_wait_select, 3'h7);
		bit_is(2, 1'b1);
		chk(read_open, 1'b1);
		chip_mode <= 2'h2;
		boot_mode <= 1'b1;
		apb(1'b1, CT, PIN);
		chk(read_open, 1'b0);
		chk(power_down, 1'b0);
		bit_is(3, 1'b1);
		bit_is(0, 1'b1);
		tally_and_finish;
	end
endmodule // fpg_host_tb_top
`default_nettype wire
